// file: hdl/sfr_map.vh
// constants for the serial flash read front end
`ifndef SFR_MAP_VH
`define SFR_MAP_VH
`define SFR_OP_NORMAL_READ 8'h03
`define SFR_OP_FAST_READ 8'h0b
`define SFR_OP_DUAL_IO_READ 8'hbb
`define SFR_OP_QUAD_IO_READ 8'heb
`define SFR_OP_UNIQUE_ID_READ 8'h4b
`define SFR_OP_INFO_ROW_READ 8'h68
`define SFR_MODE_CONT_CODE 4'ha
`define SFR_ADDR_BITS 24
`define SFR_DUMMY_SINGLE 4'h6
`define SFR_DUMMY_QUAD 4'h6
`define SFR_DUMMY_DUAL 4'h4
`define SFR_MODE_CYC_DUAL 4'h4
`define SFR_DENS_4M 3'h0
`define SFR_DENS_2M 3'h1
`define SFR_DENS_1M 3'h2
`define SFR_DENS_512K 3'h3
`define SFR_DENS_256K 3'h4
`define SFR_NORMAL_MAX_MHZ 50
`define SFR_FAST_MAX_MHZ 104
`endif

// file: hdl/sfr_buf2.v
// two-entry valid/ready buffer on the read data path
`timescale 1ns/100ps
module sfr_buf2 #(
  parameter WIDTH = 8
) (
  // clock and reset
  input wire core_clk,
  input wire resetn,
  input wire flush,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:1];
  reg wr_ptr;
  reg rd_ptr;
  reg [1:0] count;
  wire do_wr;
  wire do_rd;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rd_ptr];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end
    else if (flush)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end
    else
    begin
      if (do_wr)
        wr_ptr <= ~wr_ptr;
      if (do_rd)
        rd_ptr <= ~rd_ptr;
      if (do_wr && !do_rd)
        count <= count + 2'h1;
      else if (do_rd && !do_wr)
        count <= count - 2'h1;
    end
  end

  always @(posedge core_clk)
  begin
    if (do_wr)
      mem[wr_ptr] <= in_data;
  end
endmodule // sfr_buf2

// file: hdl/sfr_front_end.v
// read command front end of a serial flash, sampled on the core clock
`timescale 1ns/100ps
`include "sfr_map.vh"
module sfr_front_end #(
  parameter AW = `SFR_ADDR_BITS
) (
  // clock and reset
  input wire core_clk,
  input wire resetn,
  // serial link pins, sampled by core_clk
  input wire ce_n,
  input wire sck,
  input wire pause_n,
  input wire [3:0] io_in,
  output reg [3:0] io_out,
  output reg [3:0] io_oe_n,
  // configuration and status
  input wire [2:0] density_sel,
  input wire four_line_command_mode,
  input wire quad_enable_bit,
  input wire pause_pin_is_reset,
  input wire write_in_progress_flag,
  input wire [3:0] dummy_count,
  output reg continuous_read_mode,
  output reg read_active,
  // array read port
  output reg mem_req,
  output reg [AW-1:0] mem_addr,
  input wire mem_valid,
  input wire [7:0] mem_data,
  output reg mem_ready
);
  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_CMD = 3'h1;
  localparam ST_ADDR = 3'h2;
  localparam ST_DUMMY = 3'h3;
  localparam ST_DATA = 3'h4;
  localparam ST_IGNORE = 3'h5;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  reg [7:0] sync1;
  reg [7:0] sync2;
  reg sck_d;
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      // idle pin levels, so no false clock edge follows reset
      sync1 <= 8'hb0;
      sync2 <= 8'hb0;
      sck_d <= 1'b0;
    end
    else
    begin
      sync1 <= {ce_n, sck, pause_n, 1'b1, io_in};
      sync2 <= sync1;
      sck_d <= sync2[6];
    end
  end
  wire ce_s = sync2[7];
  wire sck_s = sync2[6];
  wire pause_s = sync2[5];
  wire [3:0] io_s = sync2[3:0];
  wire rise = sck_s && !sck_d;
  wire fall = !sck_s && sck_d;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function [AW-1:0] addr_mask;
    input [2:0] dens;
    begin
      case (dens)
        `SFR_DENS_4M: addr_mask = {{(AW-19){1'b0}}, {19{1'b1}}};
        `SFR_DENS_2M: addr_mask = {{(AW-18){1'b0}}, {18{1'b1}}};
        `SFR_DENS_1M: addr_mask = {{(AW-17){1'b0}}, {17{1'b1}}};
        `SFR_DENS_512K: addr_mask = {{(AW-16){1'b0}}, {16{1'b1}}};
        default: addr_mask = {{(AW-15){1'b0}}, {15{1'b1}}};
      endcase
    end
  endfunction

  function is_read_op;
    input [7:0] op;
    input quad;
    begin
      if (quad)
        is_read_op = (op == `SFR_OP_FAST_READ) || (op == `SFR_OP_QUAD_IO_READ) ||
          (op == `SFR_OP_UNIQUE_ID_READ) || (op == `SFR_OP_INFO_ROW_READ);
      else
        is_read_op = (op == `SFR_OP_NORMAL_READ) || (op == `SFR_OP_FAST_READ) ||
          (op == `SFR_OP_DUAL_IO_READ);
    end
  endfunction

  // ------------------------------------------------------------
  // sequence state
  // ------------------------------------------------------------
  reg [2:0] state;
  reg [7:0] opcode;
  reg [5:0] bit_cnt;
  reg [3:0] dummy_cnt;
  reg [AW-1:0] addr;
  reg [7:0] mode_bits;
  reg [7:0] shreg;
  reg [3:0] bits_left;
  reg [1:0] lanes;
  reg paused;
  reg have_byte;
  reg [3:0] held_oe_n;

  wire pause_allowed = !quad_enable_bit && !pause_pin_is_reset;
  wire selected = !ce_s;
  wire [3:0] width_bits = (lanes == 2'h2) ? 4'h4 : ((lanes == 2'h1) ? 4'h2 : 4'h1);
  wire [AW-1:0] next_addr = (mem_addr + {{(AW-1){1'b0}}, 1'b1}) & addr_mask(density_sel);
  wire [7:0] op_in = (lanes == 2'h2) ? {opcode[3:0], io_s} : {opcode[6:0], io_s[0]};
  wire [AW-1:0] addr_in = (lanes == 2'h2) ? {addr[AW-5:0], io_s} :
    ((lanes == 2'h1) ? {addr[AW-3:0], io_s[1:0]} : {addr[AW-2:0], io_s[0]});

  // buffer between array and shifter; a full buffer stalls the request
  wire buf_in_ready;
  wire buf_out_valid;
  wire [7:0] buf_out_data;
  wire buf_take = (state == ST_DATA) && !have_byte && buf_out_valid;
  // valid lingering after the request drops is not a new byte
  wire arr_take = mem_req && mem_valid && mem_ready && buf_in_ready;
  sfr_buf2 #(.WIDTH(8)) u_buf (
    .core_clk(core_clk),
    .resetn(resetn),
    .flush(ce_s),
    .in_valid(mem_req && mem_valid && mem_ready),
    .in_ready(buf_in_ready),
    .in_data(mem_data),
    .out_valid(buf_out_valid),
    .out_ready(buf_take),
    .out_data(buf_out_data)
  );

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= ST_IDLE;
      opcode <= 8'h00;
      bit_cnt <= 6'h00;
      dummy_cnt <= 4'h0;
      addr <= {AW{1'b0}};
      mode_bits <= 8'h00;
      shreg <= 8'h00;
      bits_left <= 4'h0;
      lanes <= 2'h0;
      paused <= 1'b0;
      have_byte <= 1'b0;
      held_oe_n <= 4'hf;
      continuous_read_mode <= 1'b0;
      read_active <= 1'b0;
      mem_req <= 1'b0;
      mem_addr <= {AW{1'b0}};
      mem_ready <= 1'b0;
      io_out <= 4'h0;
      io_oe_n <= 4'hf;
    end
    else if (!selected)
    begin
      // deselect ends any read; mode selection untouched
      state <= ST_IDLE;
      paused <= 1'b0;
      have_byte <= 1'b0;
      read_active <= 1'b0;
      mem_req <= 1'b0;
      mem_ready <= 1'b0;
      io_oe_n <= 4'hf;
    end
    else if (paused || (pause_allowed && !pause_s && !sck_s))
    begin
      // pause keeps state, floats output, ignores input
      io_oe_n <= 4'hf;
      if (arr_take)
        mem_req <= 1'b0;
      if (!paused)
        held_oe_n <= io_oe_n;
      if (pause_s && !sck_s)
      begin
        paused <= 1'b0;
        io_oe_n <= held_oe_n;
      end
      else
        paused <= 1'b1;
    end
    else
    begin
      mem_ready <= buf_in_ready;
      if (arr_take)
        mem_req <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          // new select: fresh command or straight to address
          bit_cnt <= 6'h00;
          if (continuous_read_mode)
          begin
            state <= ST_ADDR;
            opcode <= `SFR_OP_DUAL_IO_READ;
            lanes <= 2'h1;
          end
          else
          begin
            state <= ST_CMD;
            lanes <= four_line_command_mode ? 2'h2 : 2'h0;
          end
        end
        ST_CMD:
        if (rise)
        begin
          opcode <= op_in;
          bit_cnt <= bit_cnt + {2'h0, width_bits};
          if (bit_cnt + {2'h0, width_bits} == 6'h08)
          begin
            bit_cnt <= 6'h00;
            // busy device or unknown opcode: swallow the rest
            if (write_in_progress_flag || !is_read_op(op_in, four_line_command_mode))
              state <= ST_IGNORE;
            else
            begin
              state <= ST_ADDR;
              if (lanes != 2'h2 && op_in == `SFR_OP_DUAL_IO_READ)
                lanes <= 2'h1;
            end
          end
        end
        ST_ADDR:
        if (rise)
        begin
          addr <= addr_in;
          bit_cnt <= bit_cnt + {2'h0, width_bits};
          if (bit_cnt + {2'h0, width_bits} == AW[5:0])
          begin
            bit_cnt <= 6'h00;
            read_active <= 1'b1;
            state <= (opcode == `SFR_OP_NORMAL_READ) ? ST_DATA : ST_DUMMY;
            if (opcode == `SFR_OP_DUAL_IO_READ)
              dummy_cnt <= `SFR_DUMMY_DUAL;
            else if (dummy_count != 4'h0)
              dummy_cnt <= dummy_count;
            else
              dummy_cnt <= (lanes == 2'h2) ? `SFR_DUMMY_QUAD : `SFR_DUMMY_SINGLE;
            mem_req <= 1'b1;
            mem_addr <= addr_in & addr_mask(density_sel);
          end
        end
        ST_DUMMY:
        if (rise)
        begin
          // mode bits live inside the dummy window
          if (opcode == `SFR_OP_DUAL_IO_READ && bit_cnt < {2'h0, `SFR_MODE_CYC_DUAL})
          begin
            mode_bits <= {mode_bits[5:0], io_s[1:0]};
            if (bit_cnt == {2'h0, `SFR_MODE_CYC_DUAL} - 6'h1)
              continuous_read_mode <= ({mode_bits[5:0], io_s[1:0]} >> 4) ==
                {4'h0, `SFR_MODE_CONT_CODE};
          end
          bit_cnt <= bit_cnt + 6'h1;
          if (dummy_cnt == 4'h1)
            state <= ST_DATA;
          dummy_cnt <= dummy_cnt - 4'h1;
        end
        ST_DATA:
        begin
          if (buf_take)
          begin
            shreg <= buf_out_data;
            bits_left <= 4'h8;
            have_byte <= 1'b1;
            mem_addr <= next_addr;
            mem_req <= 1'b1;
          end
          if (fall && have_byte)
          begin
            // data out on falling edges, msb first, input ignored
            case (lanes)
              2'h2:
              begin
                io_out <= shreg[7:4];
                io_oe_n <= 4'h0;
                shreg <= {shreg[3:0], 4'h0};
              end
              2'h1:
              begin
                io_out <= {2'h0, shreg[7:6]};
                io_oe_n <= 4'hc;
                shreg <= {shreg[5:0], 2'h0};
              end
              default:
              begin
                io_out <= {2'h0, shreg[7], 1'b0};
                io_oe_n <= 4'hd;
                shreg <= {shreg[6:0], 1'b0};
              end
            endcase
            if (bits_left == width_bits)
              have_byte <= 1'b0;
            bits_left <= bits_left - width_bits;
          end
        end
        ST_IGNORE:
          io_oe_n <= 4'hf;
        default:
          state <= ST_IDLE;
      endcase
    end
  end
endmodule // sfr_front_end

// file: tb/sfr_props.sv
// concurrent checks on the flash read front end ports
`timescale 1ns/100ps
module sfr_props #(
  parameter AW = 24
) (
  // clock and reset
  input wire core_clk,
  input wire resetn,
  // pins and settings
  input wire ce_n,
  input wire pause_n,
  input wire [3:0] io_oe_n,
  input wire [2:0] density_sel,
  input wire quad_enable_bit,
  input wire pause_pin_is_reset,
  input wire write_in_progress_flag,
  // status and array port
  input wire continuous_read_mode,
  input wire read_active,
  input wire mem_req,
  input wire [AW-1:0] mem_addr
);
  wire [AW-1:0] top = AW'(24'h7ffff >> (density_sel > 3'h4 ? 3'h4 : density_sel));
  wire no_pause = quad_enable_bit | pause_pin_is_reset;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // pins pass a two-flop synchroniser, so effects lag three cycles
  sequence s_desel;
    ce_n [*5];
  endsequence
  sequence s_pause;
    (!ce_n && !pause_n && !no_pause) [*6];
  endsequence
  a_desel_float: assert property (s_desel |-> io_oe_n == 4'hf)
    else $error("driven while deselected");
  a_pause_float: assert property (s_pause |-> io_oe_n == 4'hf)
    else $error("driven during pause");
  a_idle_float: assert property (!read_active [*3] |-> io_oe_n == 4'hf)
    else $error("driven before data phase");
  a_ce_ends: assert property ($rose(ce_n) |-> ##[1:6] !read_active)
    else $error("read not ended");
  a_busy_ignore: assert property (write_in_progress_flag [*8] |-> !$rose(read_active))
    else $error("read started while busy");
  a_addr_mask: assert property (mem_req |-> (mem_addr & ~top) == '0)
    else $error("undecoded address bits used");
  a_mode_hold: assert property (s_desel ##1 ce_n |-> $stable(continuous_read_mode))
    else $error("mode changed while deselected");
  a_pause_off: assert property (read_active && !ce_n && !io_oe_n[1] && no_pause |=> ce_n || !io_oe_n[1])
    else $error("pause honoured while disabled");
endmodule // sfr_props
bind sfr_front_end sfr_props #(.AW(AW)) u_props (.core_clk, .resetn, .ce_n, .pause_n, .io_oe_n, .density_sel,
  .quad_enable_bit, .pause_pin_is_reset, .write_in_progress_flag, .continuous_read_mode, .read_active, .mem_req,
  .mem_addr);

// file: tb/sfr_host_model.sv
// host-side serial controller model for the flash read front end
`timescale 1ns/100ps
module sfr_host_model (
  // clock
  input wire core_clk,
  // serial pins
  output logic ce_n = 1'h1,
  output logic sck = 1'h0,
  output logic pause_n = 1'h1,
  output logic [3:0] io_in = 4'h0,
  input wire [3:0] io_out,
  input wire [3:0] io_oe_n
);
  logic [3:0] q = 4'h0;
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // output taken late in the high phase, well after the device's update
  task automatic cyc(input logic [3:0] d);
    io_in = d;
    tick(4);
    sck = 1'h1;
    tick(4);
    // a floated line reads back inverted, never its last value
    q = (io_out & ~io_oe_n) | (~q & io_oe_n);
    sck = 1'h0;
  endtask
  task automatic send(input logic [23:0] v, input int n, input int w);
    for (int i = n - w; i >= 0; i -= w)
      cyc(4'((v >> i) & ((24'h1 << w) - 24'h1)));
  endtask
  task automatic get(output logic [7:0] b, input int w);
    b = 8'h0;
    for (int i = 0; i < 8; i += w)
    begin
      // released lines toggle, never keep the last value
      cyc(~q);
      b = 8'((b << w) | (w == 1 ? {3'h0, q[1]} : w == 2 ? {2'h0, q[1:0]} : q));
    end
  endtask
  task automatic sel();
    ce_n = 1'h0;
    tick(8);
  endtask
  task automatic desel();
    tick(2);
    ce_n = 1'h1;
    tick(16);
  endtask
  task automatic pz(input logic p);
    tick(4);
    pause_n = p;
    tick(8);
  endtask
endmodule // sfr_host_model

// file: tb/tb.sv
// self-checking bench for the flash read front end
`timescale 1ns/100ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_count++; $display("BAD %s exp %h got %h", n, e, s); end end
module tb;
  logic core_clk = 1'h0;
  logic resetn = 1'h0;
  logic [2:0] density_sel = 3'h0;
  logic four_line_command_mode = 1'h0;
  logic quad_enable_bit = 1'h0;
  logic pause_pin_is_reset = 1'h0;
  logic write_in_progress_flag = 1'h0;
  logic [3:0] dummy_count = 4'h0;
  logic mem_valid = 1'h0;
  wire ce_n, sck, pause_n, continuous_read_mode, read_active, mem_req, mem_ready;
  wire [3:0] io_in, io_out, io_oe_n;
  wire [23:0] mem_addr;
  wire [7:0] mem_data = f(mem_addr);
  logic [7:0] b;
  logic [7:0] qop [4] = '{8'h0b, 8'heb, 8'h4b, 8'h68};
  int err_count = 0;
  int checks = 0;
  int cyc_n = 0;
  sfr_front_end DUT (.core_clk, .resetn, .ce_n, .sck, .pause_n, .io_in, .io_out, .io_oe_n, .density_sel,
    .four_line_command_mode, .quad_enable_bit, .pause_pin_is_reset, .write_in_progress_flag, .dummy_count,
    .continuous_read_mode, .read_active, .mem_req, .mem_addr, .mem_valid, .mem_data, .mem_ready);
  sfr_host_model h (.core_clk, .ce_n, .sck, .pause_n, .io_in, .io_out, .io_oe_n);
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk)
    mem_valid <= #1 mem_req;
  always @(posedge core_clk)
  begin
    cyc_n++;
    if (cyc_n == 20000)
    begin
      err_count++;
      finish_test();
    end
  end
  function automatic logic [7:0] f(input logic [23:0] a);
    return a[7:0] + a[15:8] + {5'h0, a[18:16]};
  endfunction
  // one whole read; w is opcode lanes, 0 when continuous mode skips it
  task automatic rd(input logic [7:0] op, input int w, aw, dm, input logic [7:0] mb,
    input logic [23:0] a, input int dw, n, input logic p = 1'h0);
    logic [23:0] m;
    m = 24'h7ffff >> (density_sel > 3'h4 ? 3'h4 : density_sel);
    h.sel();
    if (w > 0)
      h.send({16'h0, op}, 8, w);
    h.send(a, 24, aw);
    for (int i = 0; i < dm; i++)
      h.cyc(aw == 2 && i < 2 ? {2'h0, mb[7 - 2 * i -: 2]} : aw == 2 ? ~h.q : 4'h0);
    for (int j = 0; j < n; j++)
    begin
      if (j == 1 && p)
      begin
        h.pz(1'h0);
        `CHK("pause", ~(quad_enable_bit | pause_pin_is_reset), io_oe_n[1])
        if (!(quad_enable_bit | pause_pin_is_reset))
          h.send(24'hffffff, 3, 1);
        h.pz(1'h1);
      end
      h.get(b, dw);
      if (!write_in_progress_flag)
        `CHK("data", f(((a & m) + 24'(j)) & m), b)
    end
    if (write_in_progress_flag)
      `CHK("busy", 4'hf, io_oe_n)
    h.desel();
  endtask
  task automatic finish_test();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge core_clk);
    #1 resetn = 1'h1;
    h.tick(4);
    for (int d = 0; d < 5; d++)
    begin
      density_sel = 3'(d);
      rd(8'h03, 1, 1, 0, 8'h0, 24'hffffff, 1, 2);
    end
    `CHK("oe", 4'hf, io_oe_n)
    `CHK("act", 1'h0, read_active)
    density_sel = 3'h0;
    for (int k = 0; k < 2; k++)
    begin
      dummy_count = k ? 4'h8 : 4'h0;
      rd(8'h0b, 1, 1, 6 + 2 * k, 8'h0, 24'h012345, 1, 2);
    end
    dummy_count = 4'h0;
    four_line_command_mode = 1'h1;
    foreach (qop[i])
      rd(qop[i], 4, 4, 6, 8'h0, 24'h0abcde, 4, 2);
    four_line_command_mode = 1'h0;
    rd(8'hbb, 1, 2, 4, 8'ha5, 24'h001234, 2, 2);
    `CHK("cont", 1'h1, continuous_read_mode)
    rd(8'h00, 0, 2, 4, 8'h50, 24'h07fffe, 2, 3);
    `CHK("cont", 1'h0, continuous_read_mode)
    write_in_progress_flag = 1'h1;
    rd(8'h03, 1, 1, 0, 8'h0, 24'h000100, 1, 1);
    write_in_progress_flag = 1'h0;
    for (int k = 0; k < 3; k++)
    begin
      {quad_enable_bit, pause_pin_is_reset} = 2'(k);
      rd(8'h03, 1, 1, 0, 8'h0, 24'h000200, 1, 2, 1'h1);
    end
    finish_test();
  end
endmodule // tb
